//--- bench/audio_serial_clock_master_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module audio_serial_clock_master_config_tb;
  logic sys_clk = 0, rstn = 0, wr = 0, rd = 0, spec = 0;
  logic [7:0] adr = 0, wd = 0, rdat;
  logic hb, hf, bo, bon, fo, fon, bs, fs, ln, pr, se, rh, au, cu, pl;
  logic gt, fm, rf, rcr, rtr, pb, pf;
  logic [1:0] h, g;
  logic [5:0] sl;
  logic [4:0] hs;
  audio_serial_pkg::clock_role_e role;
  audio_serial_pkg::frame_len_t flen;
  audio_serial_pkg::rate_hz_t srate;
  audio_serial_pkg::ref_khz_t rkhz;
  int error_cnt = 0, n_checks = 0, seed = 32'h17a83142;
  int r8 = 7, ra = 2, rb = 'h48, k, v;
  int lt[16] = '{16,24,32,48,64,96,128,192,256,384,512,1024,2048,0,0,0};
  int r48[9] = '{8,16,24,32,48,96,192,384,768};
  int r44[9] = '{7350,14700,22050,29400,44100,88200,176400,352800,705600};
  int rk[8] = '{12000,12288,13000,16000,19200,19680,24000,24576};

  // 40 MHz clock
  initial forever #12.5 sys_clk = ~sys_clk;

  audio_serial_clock_master_config dut_u (.sys_clk(sys_clk), .rstn(rstn),
    .ce(1'b1), .reg_addr(adr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd),
    .reg_rdata(rdat), .ref_clock_spec_mode(spec), .bclk_in(hb),
    .bclk_out(bo), .bclk_oe_n(bon), .frame_sync_in(hf), .frame_sync_out(fo),
    .frame_sync_oe_n(fon), .bclk_sync(bs), .frame_sync_sync(fs),
    .ch_eight_slot_index(sl), .ch_eight_line_select(ln),
    .ch_eight_on_primary(pr), .ch_eight_on_secondary(se),
    .ch_eight_right_half(rh), .ch_eight_half_slot(hs),
    .clock_role_select(role), .auto_clock_derive(au),
    .custom_clock_needed(cu), .pll_in_use(pl), .outgoing_clock_gate(gt),
    .rate_family_select(fm), .ref_from_frame_sync_multiple(rf),
    .frame_len(flen), .sample_rate_hz(srate), .ref_clock_khz(rkhz),
    .rate_code_reserved(rcr), .ratio_code_reserved(rtr));

  host_clock_model host_u (.sys_clk(sys_clk), .run(bon), .bclk(hb),
    .frame_sync(hf));

  task automatic chk(input string n, input logic [19:0] e, s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %0h got %0h", n, e, s);
    end
  endtask

  // Bus strobes last one cycle; decoded values settle one edge later
  task automatic wr_reg(input logic [7:0] a, d);
    @(negedge sys_clk) {adr, wd, wr} = {a, d, 1'b1};
    @(negedge sys_clk) wr = 0;
    if (a == 8'h12) r8 = d & 'h7F;
    if (a == 8'h13) ra = d;
    if (a == 8'h14) rb = d;
    @(negedge sys_clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, input int e);
    @(negedge sys_clk) {adr, rd} = {a, 1'b1};
    @(negedge sys_clk) rd = 0;
    chk("rdata", e, rdat);
  endtask

  // Every decoded output against the integer model
  task automatic cmp();
    int m, c, r, b;
    m = ra >> 7;
    c = m | ra >> 6 & 1;
    r = rb >> 4;
    b = rb & 15;
    chk("slot", r8 & 63, sl);
    chk("half", r8 & 63, {rh, hs});
    chk("line", r8[6] ? 5 : 2, {ln, pr, se});
    chk("role", m ? 4 : 3, {role, bon, fon});
    chk("auto", ra[6] ? 2 : ra[5] ? 4 : 5, {au, cu, pl});
    chk("gate", m ? {ra[4], ra[3], spec} : 0, {gt, fm, rf});
    if (gt) chk("gated", 0, {bo, fo});
    chk("ratio", c ? lt[b] : 0, flen);
    chk("rate", c && r < 9 ? (m && ra[3] ? r44[r] : r48[r] * 1000) : 0,
      srate);
    chk("ref", m && !spec ? rk[ra & 7] : 0, rkhz);
    chk("rsv", c ? {r > 8, b > 12} : 0, {rcr, rtr});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (16) @(negedge sys_clk);
    rstn = 1;
    rd_reg(8'h12, 7);
    rd_reg(8'h13, 2);
    rd_reg(8'h14, 'h48);
    rd_reg(8'h15, 0);
    cmp();
    $display("test reset done");
    repeat (8) begin
      wr_reg(8'h12, 8'($random(seed)));
      rd_reg(8'h12, r8);
      cmp();
    end
    $display("test route done");
    for (k = 0; k < 16; k++) begin
      wr_reg(8'h13, 8'(8'h80 | k));
      wr_reg(8'h14, 8'(k * 17));
      rd_reg(8'h14, rb);
      cmp();
    end
    $display("test codes done");
    repeat (24) begin
      v = $random(seed);
      @(negedge sys_clk) spec = v[8];
      wr_reg(8'h13, v[7:0]);
      wr_reg(8'h14, v[23:16]);
      cmp();
    end
    $display("test random done");
    // Slave: pins pass a two-flop synchroniser
    wr_reg(8'h13, 8'h00);
    for (k = 0; k < 40; k++) begin
      @(negedge sys_clk);
      if (k > 1) chk("sync", {h[1], g[1]}, {bs, fs});
      h = {h[0], hb};
      g = {g[0], hf};
    end
    $display("test slave done");
    // Master, 16 bit clocks of 4 cycles per frame
    wr_reg(8'h14, 8'h40);
    wr_reg(8'h13, 8'h90);
    cmp();
    wr_reg(8'h13, 8'h80);
    {pb, pf, k, v} = {bo, fo, 64'h0};
    repeat (64) begin
      @(negedge sys_clk);
      k += int'(bo & !pb);
      v += int'(fo & !pf);
      {pb, pf} = {bo, fo};
    end
    chk("bclks", 16, k);
    chk("frames", 1, v);
    $display("test master done");
    wrap_up();
  end
endmodule // audio_serial_clock_master_config_tb
`default_nettype wire

//--- bench/host_clock_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_clock_model (
  input wire logic sys_clk, // System clock
  input wire logic run, // Host owns the clocks
  output var logic bclk, // Bit clock to device
  output var logic frame_sync // Frame sync to device
);
  int cnt = 0;
  initial {bclk, frame_sync} = 2'b00;
  // Host drives only while device is slave; released lines toggle
  always @(posedge sys_clk) begin
    cnt <= cnt + 1;
    bclk <= run ? cnt[2] : ~bclk;
    frame_sync <= run ? (cnt[6:3] == 4'h0) : ~frame_sync;
  end
endmodule // host_clock_model
`default_nettype wire

//--- design/audio_serial_clock_master_config.sv
// How it works
// - Line bit 6 clear sends channel 8 on primary output, set on secondary.
// - Six-bit slot field: 0-31 left or TDM slot, 32-63 right half.
// - Channel 8 register resets to slot 7 on primary output.
// - Role bit 0 takes bit clock and frame sync in; 1 drives both.
// - Auto clock bit 0 derives dividers and PLL; 1 needs custom setup.
// - In auto mode PLL used when bypass bit 5 is 0.
// - Master gate bit 4 forces outgoing bit clock and frame sync off.
// - Master family bit 3: 0 is 48 kHz family, 1 is 44.1 kHz.
// - Three-bit code picks reference of 12 to 24.576 MHz in master mode.
// - Sample rate code 0-8 picks rate pair; 9-15 reserved.
// - Ratio code gives bit clocks per frame; 13-15 reserved.
// - Config B resets to 48h, config A to 02h.
// - Spec mode 1 takes reference as a frame sync multiple in master mode.
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_defs.svh"

module audio_serial_clock_master_config (
  input wire logic sys_clk, // System clock, 40 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic [7:0] reg_addr, // Register address on page 0
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_wdata, // Register write data
  output logic [7:0] reg_rdata, // Register read data
  input wire logic ref_clock_spec_mode, // Reference spec mode
  input wire logic bclk_in, // Bit clock pin input
  output logic bclk_out, // Bit clock pin output
  output logic bclk_oe_n, // Bit clock drive enable, low drives
  input wire logic frame_sync_in, // Frame sync pin input
  output logic frame_sync_out, // Frame sync pin output
  output logic frame_sync_oe_n, // Frame sync drive enable, low drives
  output logic bclk_sync, // Bit clock pin after synchroniser
  output logic frame_sync_sync, // Frame sync pin after synchroniser
  output logic [5:0] ch_eight_slot_index, // Channel 8 slot
  output logic ch_eight_line_select, // Channel 8 output line
  output logic ch_eight_on_primary, // Channel 8 on primary serial out
  output logic ch_eight_on_secondary, // Channel 8 on secondary pin
  output logic ch_eight_right_half, // Slot in right half of frame
  output logic [4:0] ch_eight_half_slot, // Slot within its half
  output audio_serial_pkg::clock_role_e clock_role_select, // Clock role
  output logic auto_clock_derive, // Dividers derived automatically
  output logic custom_clock_needed, // Custom clock setup required
  output logic pll_in_use, // PLL used in auto mode
  output logic outgoing_clock_gate, // Outgoing clocks gated
  output logic rate_family_select, // 1 is 44.1 kHz family
  output logic ref_from_frame_sync_multiple, // Ref is a frame sync multiple
  output audio_serial_pkg::frame_len_t frame_len, // Bit clocks per frame
  output audio_serial_pkg::rate_hz_t sample_rate_hz, // Sample rate in Hz
  output audio_serial_pkg::ref_khz_t ref_clock_khz, // Reference in kHz
  output logic rate_code_reserved, // Reserved sample rate code
  output logic ratio_code_reserved // Reserved ratio code
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [6:0] ch8_q;
  logic [7:0] cfg_a_q;
  logic [7:0] cfg_b_q;
  logic [7:0] rdata_q;
  logic seen_q;
  logic master;
  logic codes_in_use;
  logic gen_bclk;
  logic gen_frame_sync;
  logic gen_run;

  // Decode of the register address, one helper shared by writes and reads
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    if (a == `CH8_ROUTE_OFFSET) begin
      reg_sel = 2'h1;
    end else if (a == `CFG_A_OFFSET) begin
      reg_sel = 2'h2;
    end else if (a == `CFG_B_OFFSET) begin
      reg_sel = 2'h3;
    end else begin
      reg_sel = 2'h0;
    end
  endfunction

  // Channel 8 routing; reserved bit 7 is not stored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ch8_q <= 7'(`CH8_ROUTE_RESET);
    end else if (ce && reg_wr && reg_sel(reg_addr) == 2'h1) begin
      ch8_q <= reg_wdata[6:0];
    end
  end

  // Master configuration A
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_a_q <= `CFG_A_RESET;
    end else if (ce && reg_wr && reg_sel(reg_addr) == 2'h2) begin
      cfg_a_q <= reg_wdata;
    end
  end

  // Master configuration B
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_b_q <= `CFG_B_RESET;
    end else if (ce && reg_wr && reg_sel(reg_addr) == 2'h3) begin
      cfg_b_q <= reg_wdata;
    end
  end

  // Read data is held until the next read; unmapped reads as zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (ce && reg_rd) begin
      if (reg_sel(reg_addr) == 2'h1) begin
        rdata_q <= {1'b0, ch8_q};
      end else if (reg_sel(reg_addr) == 2'h2) begin
        rdata_q <= cfg_a_q;
      end else if (reg_sel(reg_addr) == 2'h3) begin
        rdata_q <= cfg_b_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign reg_rdata = rdata_q;

  // Marks the first enabled edge after reset, used only by checks
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seen_q <= 1'b0;
    end else if (ce) begin
      seen_q <= 1'b1;
    end
  end

  // ****************************************
  // Field decode
  // ****************************************
  // Slot routing straight from the stored fields
  assign ch_eight_slot_index = ch8_q[`CH_EIGHT_SLOT_INDEX_MSB:0];
  assign ch_eight_line_select = ch8_q[`CH8_LINE_POS];
  assign ch_eight_on_primary = ~ch8_q[`CH8_LINE_POS];
  assign ch_eight_on_secondary = ch8_q[`CH8_LINE_POS];
  assign ch_eight_right_half = ch8_q[`CH_EIGHT_SLOT_INDEX_MSB];
  assign ch_eight_half_slot = ch8_q[4:0];

  // Role and clocking modes
  assign master = cfg_a_q[`ROLE_POS];
  assign clock_role_select = master ? audio_serial_pkg::ROLE_MASTER :
    audio_serial_pkg::ROLE_SLAVE;
  assign auto_clock_derive = ~cfg_a_q[`AUTO_CLK_POS];
  assign custom_clock_needed = cfg_a_q[`AUTO_CLK_POS];
  assign pll_in_use = auto_clock_derive & ~cfg_a_q[`PLL_BYP_POS];
  assign outgoing_clock_gate = master & cfg_a_q[`GATE_POS];
  assign rate_family_select = master & cfg_a_q[`FAMILY_POS];
  assign ref_from_frame_sync_multiple = master & ref_clock_spec_mode;

  // Rate and ratio codes are dropped only in automatic slave mode
  assign codes_in_use = master | custom_clock_needed;

  clock_code_decode u_decode (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .codes_in_use(codes_in_use),
    .master(master),
    .rate_family_select(cfg_a_q[`FAMILY_POS]),
    .ref_clock_spec_mode(ref_clock_spec_mode),
    .ref_clock_freq_code(cfg_a_q[`FREQ_MSB:0]),
    .sample_rate_code(cfg_b_q[`RATE_MSB:`RATE_LSB]),
    .bits_per_frame_code(cfg_b_q[`RATIO_MSB:0]),
    .frame_len(frame_len),
    .sample_rate_hz(sample_rate_hz),
    .ref_clock_khz(ref_clock_khz),
    .rate_code_reserved(rate_code_reserved),
    .ratio_code_reserved(ratio_code_reserved)
  );

  // ****************************************
  // Clock pins
  // ****************************************
  // Generator idles on a reserved ratio rather than emit a bad frame
  assign gen_run = master && frame_len != 12'h000;

  serial_clock_gen u_gen (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .ce(ce),
    .run(gen_run),
    .frame_len(frame_len),
    .bclk_q(gen_bclk),
    .frame_sync_q(gen_frame_sync)
  );

  // Gate holds the pins low but still driven, so the bus never floats
  assign bclk_out = gen_bclk & ~outgoing_clock_gate;
  assign frame_sync_out = gen_frame_sync & ~outgoing_clock_gate;
  assign bclk_oe_n = ~master;
  assign frame_sync_oe_n = ~master;

  // Pin inputs pass two flops before use
  logic [1:0] bclk_meta_q;
  logic [1:0] frame_sync_meta_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bclk_meta_q <= 2'b00;
      frame_sync_meta_q <= 2'b00;
    end else if (ce) begin
      bclk_meta_q <= {bclk_meta_q[0], bclk_in};
      frame_sync_meta_q <= {frame_sync_meta_q[0], frame_sync_in};
    end
  end

  assign bclk_sync = bclk_meta_q[1];
  assign frame_sync_sync = frame_sync_meta_q[1];

  // ****************************************
  // Checks
  // ****************************************
  property p_ch8_reset;
    @(posedge sys_clk) disable iff (!rstn)
    !seen_q |-> ch_eight_slot_index == 6'h07 && !ch_eight_line_select;
  endproperty
  a_ch8_reset: assert property (p_ch8_reset) else $error("ch8 reset");

  property p_cfg_reset;
    @(posedge sys_clk) disable iff (!rstn)
    !seen_q |-> cfg_a_q == 8'h02 && cfg_b_q == 8'h48;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("cfg reset");

  sequence s_ch8_write;
    ce && reg_wr && reg_addr == 8'h12;
  endsequence

  property p_ch8_route;
    @(posedge sys_clk) disable iff (!rstn)
    s_ch8_write ##1 !(ce && reg_wr && reg_addr == 8'h12)
      |-> ch_eight_on_secondary == $past(reg_wdata[6])
      && ch_eight_on_primary != ch_eight_on_secondary;
  endproperty
  a_ch8_route: assert property (p_ch8_route) else $error("ch8 line");

  property p_ch_eight_slot_index;
    @(posedge sys_clk) disable iff (!rstn)
    s_ch8_write |=> ch_eight_right_half == $past(reg_wdata[5])
      && ch_eight_half_slot == $past(reg_wdata[4:0]);
  endproperty
  a_ch_eight_slot_index: assert property (p_ch_eight_slot_index) else $error("ch_eight_slot_index");

  property p_read_ch8;
    @(posedge sys_clk) disable iff (!rstn)
    ce && reg_rd && reg_addr == 8'h12 && !reg_wr
      |=> reg_rdata == ({2'b00, $past(ch_eight_slot_index)} |
        {1'b0, $past(ch_eight_line_select), 6'h00});
  endproperty
  a_read_ch8: assert property (p_read_ch8) else $error("ch8 read");

  property p_role_pins;
    @(posedge sys_clk) disable iff (!rstn)
    bclk_oe_n == (clock_role_select == audio_serial_pkg::ROLE_SLAVE)
      && frame_sync_oe_n == bclk_oe_n;
  endproperty
  a_role_pins: assert property (p_role_pins) else $error("pin drive");

  property p_gate;
    @(posedge sys_clk) disable iff (!rstn)
    master && cfg_a_q[4] |-> !bclk_out && !frame_sync_out && !bclk_oe_n;
  endproperty
  a_gate: assert property (p_gate) else $error("gate leak");

  property p_slave_quiet;
    @(posedge sys_clk) disable iff (!rstn)
    ce && !master |=> !gen_bclk;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drove");

  property p_pll;
    @(posedge sys_clk) disable iff (!rstn)
    pll_in_use == (!cfg_a_q[6] && !cfg_a_q[5]);
  endproperty
  a_pll: assert property (p_pll) else $error("pll use");

  property p_family;
    @(posedge sys_clk) disable iff (!rstn)
    ce && master && cfg_a_q[3] && cfg_b_q[7:4] == 4'h4
      |=> sample_rate_hz == 20'h0AC44;
  endproperty
  a_family: assert property (p_family) else $error("family");

  property p_auto_slave;
    @(posedge sys_clk) disable iff (!rstn)
    ce && !master && !cfg_a_q[6] |=> frame_len == 12'h000
      && sample_rate_hz == 20'h00000;
  endproperty
  a_auto_slave: assert property (p_auto_slave) else $error("codes used");

  property p_spec_mode;
    @(posedge sys_clk) disable iff (!rstn)
    ce && ref_clock_spec_mode |=> ref_clock_khz == 15'h0000;
  endproperty
  a_spec_mode: assert property (p_spec_mode) else $error("spec mode");

endmodule // audio_serial_clock_master_config

`default_nettype wire

//--- design/audio_serial_defs.svh
`ifndef AUDIO_SERIAL_DEFS_SVH
`define AUDIO_SERIAL_DEFS_SVH

// ****************************************
// Register offsets and reset values
// ****************************************
`define CH8_ROUTE_OFFSET 8'h12
`define CFG_A_OFFSET 8'h13
`define CFG_B_OFFSET 8'h14
`define CH8_ROUTE_RESET 8'h07
`define CFG_A_RESET 8'h02
`define CFG_B_RESET 8'h48

// ****************************************
// Field positions
// ****************************************
`define CH8_LINE_POS 6
`define CH_EIGHT_SLOT_INDEX_MSB 5
`define ROLE_POS 7
`define AUTO_CLK_POS 6
`define PLL_BYP_POS 5
`define GATE_POS 4
`define FAMILY_POS 3
`define FREQ_MSB 2
`define RATE_MSB 7
`define RATE_LSB 4
`define RATIO_MSB 3

// ****************************************
// Timing
// ****************************************
`define BCLK_HALF_CYCLES 4'h2

`endif

//--- design/audio_serial_pkg.sv
package audio_serial_pkg;

  // Who owns bit clock and frame sync
  typedef enum logic {
    ROLE_SLAVE = 1'b0,
    ROLE_MASTER = 1'b1
  } clock_role_e;

  typedef logic [11:0] frame_len_t;
  typedef logic [19:0] rate_hz_t;
  typedef logic [14:0] ref_khz_t;

endpackage

//--- design/clock_code_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_defs.svh"

module clock_code_decode (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic codes_in_use, // Rate and ratio codes honoured
  input wire logic master, // Master mode
  input wire logic rate_family_select, // 1 selects 44.1 kHz family in master mode
  input wire logic ref_clock_spec_mode, // 1 ref is a frame sync multiple
  input wire logic [2:0] ref_clock_freq_code, // Reference frequency code
  input wire logic [3:0] sample_rate_code, // Sample rate code
  input wire logic [3:0] bits_per_frame_code, // Bit clocks per frame code
  output audio_serial_pkg::frame_len_t frame_len, // Bit clocks per frame
  output audio_serial_pkg::rate_hz_t sample_rate_hz, // Sample rate in Hz
  output audio_serial_pkg::ref_khz_t ref_clock_khz, // Reference in kHz
  output logic rate_code_reserved, // Sample rate code reserved
  output logic ratio_code_reserved // Ratio code reserved
);

  // ****************************************
  // Code tables
  // ****************************************
  function automatic audio_serial_pkg::frame_len_t ratio_of(
    input logic [3:0] code
  );
    case (code)
      4'h0: ratio_of = 12'h010;
      4'h1: ratio_of = 12'h018;
      4'h2: ratio_of = 12'h020;
      4'h3: ratio_of = 12'h030;
      4'h4: ratio_of = 12'h040;
      4'h5: ratio_of = 12'h060;
      4'h6: ratio_of = 12'h080;
      4'h7: ratio_of = 12'h0C0;
      4'h8: ratio_of = 12'h100;
      4'h9: ratio_of = 12'h180;
      4'hA: ratio_of = 12'h200;
      4'hB: ratio_of = 12'h400;
      4'hC: ratio_of = 12'h800;
      default: ratio_of = 12'h000;
    endcase
  endfunction

  // Family bit picks the 44.1 kHz column
  function automatic audio_serial_pkg::rate_hz_t rate_of(
    input logic [3:0] code,
    input logic fam
  );
    case (code)
      4'h0: rate_of = fam ? 20'h01CB6 : 20'h01F40;
      4'h1: rate_of = fam ? 20'h0396C : 20'h03E80;
      4'h2: rate_of = fam ? 20'h05622 : 20'h05DC0;
      4'h3: rate_of = fam ? 20'h072D8 : 20'h07D00;
      4'h4: rate_of = fam ? 20'h0AC44 : 20'h0BB80;
      4'h5: rate_of = fam ? 20'h15888 : 20'h17700;
      4'h6: rate_of = fam ? 20'h2B110 : 20'h2EE00;
      4'h7: rate_of = fam ? 20'h56220 : 20'h5DC00;
      4'h8: rate_of = fam ? 20'hAC440 : 20'hBB800;
      default: rate_of = 20'h00000;
    endcase
  endfunction

  function automatic audio_serial_pkg::ref_khz_t ref_of(
    input logic [2:0] code
  );
    case (code)
      3'h0: ref_of = 15'h2EE0;
      3'h1: ref_of = 15'h3000;
      3'h2: ref_of = 15'h32C8;
      3'h3: ref_of = 15'h3E80;
      3'h4: ref_of = 15'h4B00;
      3'h5: ref_of = 15'h4CE0;
      3'h6: ref_of = 15'h5DC0;
      default: ref_of = 15'h6000;
    endcase
  endfunction

  // ****************************************
  // Registered decode
  // ****************************************
  // Codes are ignored in automatic slave mode, so outputs read zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frame_len <= 12'h000;
      sample_rate_hz <= 20'h00000;
      ratio_code_reserved <= 1'b0;
      rate_code_reserved <= 1'b0;
    end else if (ce) begin
      frame_len <= codes_in_use ? ratio_of(bits_per_frame_code) : 12'h000;
      sample_rate_hz <= codes_in_use ?
        rate_of(sample_rate_code, rate_family_select & master) : 20'h00000;
      ratio_code_reserved <= codes_in_use && bits_per_frame_code > 4'hC;
      rate_code_reserved <= codes_in_use && sample_rate_code > 4'h8;
    end
  end

  // Fixed code only counts in master mode with spec mode clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ref_clock_khz <= 15'h0000;
    end else if (ce) begin
      ref_clock_khz <= (master && !ref_clock_spec_mode) ?
        ref_of(ref_clock_freq_code) : 15'h0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_ratio_big;
    @(posedge sys_clk) disable iff (!rstn)
    ce && codes_in_use && bits_per_frame_code == 4'hB |=> frame_len == 12'h400;
  endproperty
  a_ratio_big: assert property (p_ratio_big) else $error("ratio 11 wrong");

  property p_ratio_own;
    @(posedge sys_clk) disable iff (!rstn)
    ce && codes_in_use && bits_per_frame_code == 4'h9 |=> frame_len == 12'h180;
  endproperty
  a_ratio_own: assert property (p_ratio_own) else $error("ratio 9 wrong");

  property p_rate_resv;
    @(posedge sys_clk) disable iff (!rstn)
    ce && sample_rate_code > 4'h8 |=> sample_rate_hz == 20'h00000;
  endproperty
  a_rate_resv: assert property (p_rate_resv) else $error("reserved rate");

  property p_ref_code;
    @(posedge sys_clk) disable iff (!rstn)
    ce && master && !ref_clock_spec_mode && ref_clock_freq_code == 3'h5
      |=> ref_clock_khz == 15'h4CE0;
  endproperty
  a_ref_code: assert property (p_ref_code) else $error("ref 5 wrong");

endmodule // clock_code_decode

`default_nettype wire

//--- design/serial_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "audio_serial_defs.svh"

module serial_clock_gen (
  input wire logic sys_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic run, // Master mode with a valid ratio
  input wire audio_serial_pkg::frame_len_t frame_len, // Bit clocks per frame
  output logic bclk_q, // Generated bit clock
  output logic frame_sync_q // Generated frame sync, first bit high
);

  logic [3:0] half_cnt_q;
  logic [11:0] bit_cnt_q;
  logic fall;

  // Bit clock falls on the last half-period count while high
  assign fall = bclk_q && half_cnt_q == `BCLK_HALF_CYCLES - 4'h1;

  // ****************************************
  // Bit clock divider
  // ****************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      half_cnt_q <= 4'h0;
      bclk_q <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        half_cnt_q <= 4'h0;
        bclk_q <= 1'b0;
      end else if (half_cnt_q == `BCLK_HALF_CYCLES - 4'h1) begin
        half_cnt_q <= 4'h0;
        bclk_q <= ~bclk_q;
      end else begin
        half_cnt_q <= half_cnt_q + 4'h1;
      end
    end
  end

  // Frame counter advances on falling bit clock so sync is stable on rise
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_q <= 12'h000;
      frame_sync_q <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        bit_cnt_q <= 12'h000;
        frame_sync_q <= 1'b0;
      end else if (fall) begin
        if (bit_cnt_q >= frame_len - 12'h001) begin
          bit_cnt_q <= 12'h000;
          frame_sync_q <= 1'b1;
        end else begin
          bit_cnt_q <= bit_cnt_q + 12'h001;
          frame_sync_q <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_high_two;
    $past(bclk_q) && bclk_q ##1 !bclk_q;
  endsequence

  property p_bclk_half;
    @(posedge sys_clk) disable iff (!rstn)
    ce && run && !bclk_q && half_cnt_q == 4'h1 ##1 (ce && run) [*2]
      |-> s_high_two;
  endproperty
  a_bclk_half: assert property (p_bclk_half) else $error("bclk period");

endmodule // serial_clock_gen

`default_nettype wire
